// >>> core/tss_pkg.sv
// Purpose: types of the touch scan sequencer
// Assumes: nothing beyond the map header
// Notes: channel codes double as result register index
package tss_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SETTLE, ST_OH, ST_CONV, ST_STORE} tss_state_e;
  typedef enum logic [2:0] {CH_X, CH_Y, CH_Z1, CH_Z2, CH_T1, CH_T2} tss_ch_e;
endpackage : tss_pkg

// >>> core/tss_scan_map.svh
// Purpose: register map, fields, commands and timing of the touch scan sequencer
// Assumes: 50 MHz core clock, 32-bit AXI4-Lite register words
// Notes: cycle counts are derived from times in ns and the clock rate
// Functional notes
// - touch pulls pen interrupt output low
// - coordinate-only scan ends after X stored
// - pressure scan adds two pressure conversions after X
// - X/Y scan time: 2.5us lead plus stages
// - X/Y/Z scan time: 4.75us lead plus stages
// - host-started mode: no self start after touch
// - host-stepped: drivers, host delay, then convert
// - stepped conversion: 2.125us lead plus stages
// - first temperature: low bias, one conversion
// - differential temperature: second conversion, 82x bias
// - averaging stores only the averaged value
// - self-run checks touch after Y, then X
// - falling result-ready edge marks completed results
// - results right-justified, upper bits zero
`ifndef TSS_SCAN_MAP_SVH
`define TSS_SCAN_MAP_SVH
// register byte offsets
`define TSS_CTRL_OFS 8'h00
`define TSS_SETTLE_OFS 8'h04
`define TSS_STS_OFS 8'h08
`define TSS_MASK_OFS 8'h0c
`define TSS_RES_BASE 8'h10
`define TSS_RES_LAST 8'h24
// control fields
`define TSS_CTRL_AUTO_BIT 4
`define TSS_CTRL_Z_BIT 5
`define TSS_CTRL_AVG_LSB 6
// status fields
`define TSS_STS_TOUCH_BIT 0
`define TSS_STS_DONE_BIT 1
`define TSS_STS_BUSY_BIT 8
`define TSS_STS_PEN_BIT 9
// reset values
`define TSS_CTRL_RST 32'h0000_0000
`define TSS_SETTLE_RST 32'h0004_0064
`define TSS_MASK_RST 32'h0000_0000
// commands in control bits 3:0
`define TSS_CMD_SCAN_XY 4'h1
`define TSS_CMD_SCAN_XYZ 4'h2
`define TSS_CMD_ONE_X 4'h3
`define TSS_CMD_ONE_Y 4'h4
`define TSS_CMD_ONE_Z 4'h5
`define TSS_CMD_DRV_X 4'h6
`define TSS_CMD_DRV_Y 4'h7
`define TSS_CMD_DRV_Z 4'h8
`define TSS_CMD_CONV 4'h9
`define TSS_CMD_TEMP_SINGLE_RESULT 4'ha
`define TSS_CMD_TEMP_DIFF_RESULT 4'hb
`define TSS_CMD_DRV_OFF 4'hc
// timing
`define TSS_ADC_BITS 12
`define TSS_CLK_MHZ 50
`define TSS_LEAD_XY_NS 2500
`define TSS_LEAD_XYZ_NS 4750
`define TSS_LEAD_ONE_NS 2125
`define TSS_CONV_OH_NS 4400
`define TSS_LEAD_XY_CYC ((`TSS_LEAD_XY_NS * `TSS_CLK_MHZ + 999) / 1000)
`define TSS_LEAD_XYZ_CYC ((`TSS_LEAD_XYZ_NS * `TSS_CLK_MHZ + 999) / 1000)
`define TSS_LEAD_ONE_CYC ((`TSS_LEAD_ONE_NS * `TSS_CLK_MHZ + 999) / 1000)
`define TSS_CONV_OH_CYC ((`TSS_CONV_OH_NS * `TSS_CLK_MHZ + 999) / 1000)
`endif

// >>> core/tss_scan_top.sv
// Purpose: touch panel and temperature scan sequencer with AXI4-Lite registers
// Assumes: pen_touch, conv_clk and adc_data arrive from outside the clock domain
// Notes: one sequence at a time; commands during a sequence are dropped
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "tss_scan_map.svh"
module tss_scan_top
  import tss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // panel and converter
  input wire logic pen_touch,
  input wire logic conv_clk,
  input wire logic [11:0] adc_data,
  output logic drv_x,
  output logic drv_y,
  output logic drv_z,
  output logic temp_bias_lo,
  output logic temp_bias_hi,
  output logic adc_sample,
  // host signalling
  output logic pen_touch_irq_n,
  output logic result_ready_n,
  output logic irq
);
  localparam logic [16:0] LEAD_XY = 17'(`TSS_LEAD_XY_CYC);
  localparam logic [16:0] LEAD_XYZ = 17'(`TSS_LEAD_XYZ_CYC);
  localparam logic [16:0] LEAD_ONE = 17'(`TSS_LEAD_ONE_CYC);
  localparam logic [16:0] OH_CYC = 17'(`TSS_CONV_OH_CYC);
  localparam logic [3:0] LAST_EDGE = 4'(`TSS_ADC_BITS - 1);

  // pin synchronisers; first stages feed only second stages
  logic [2:0] touch_sq;
  logic [2:0] cclk_sq;
  logic [11:0] adc_m;
  logic [11:0] adc_s;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      touch_sq <= 3'h0;
      cclk_sq <= 3'h0;
      adc_m <= 12'h000;
      adc_s <= 12'h000;
    end
    else
    begin
      touch_sq <= {touch_sq[1:0], pen_touch};
      cclk_sq <= {cclk_sq[1:0], conv_clk};
      adc_m <= adc_data;
      adc_s <= adc_m;
    end
  end
  logic touch_s;
  logic touch_rise;
  logic conv_rise;
  assign touch_s = touch_sq[1];
  assign touch_rise = touch_sq[1] & ~touch_sq[2];
  assign conv_rise = cclk_sq[1] & ~cclk_sq[2];

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic settles(input tss_ch_e c);
    return (c == CH_X) || (c == CH_Y) || (c == CH_Z1);
  endfunction : settles

  // bus state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] ctrl_q, ctrl_d, settle_q, settle_d, mask_q, mask_d, sts_q, sts_d;
  logic irq_q, irq_d;
  logic cmd_stb, rd_res_stb;
  logic [3:0] cmd_val;
  // sequencer state
  tss_state_e state_q, state_d;
  tss_ch_e ch_q, ch_d;
  logic [16:0] cnt_q, cnt_d;
  logic [3:0] avg_q, avg_d, edg_q, edg_d;
  logic [14:0] acc_q, acc_d;
  logic scan_q, scan_d, zw_q, zw_d, td_q, td_d;
  logic [2:0] hdrv_q, hdrv_d;
  logic [15:0] res_q [6];
  logic [15:0] res_d [6];
  logic done_pulse;
  logic rdy_n_q, rdy_n_d, pen_n_q;
  logic [2:0] drv_q, drv_d;
  logic blo_q, blo_d, bhi_q, bhi_d, smp_q, smp_d;

  // bus slave; write address and data may come in either order
  always_comb
  begin
    logic [7:0] ra;
    logic hit;
    ra = araddr;
    hit = 1'b0;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    wa_d = wa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    settle_d = settle_q;
    mask_d = mask_q;
    sts_d = sts_q;
    cmd_stb = 1'b0;
    cmd_val = 4'h0;
    rd_res_stb = 1'b0;
    if (awvalid && awready_q)
    begin
      aw_hold_d = 1'b1;
      wa_d = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_hold_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (aw_hold_q && w_hold_q && !bvalid_q)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'b00;
      if (wa_q == `TSS_CTRL_OFS)
      begin
        ctrl_d = merge(ctrl_q, wd_q, ws_q);
        cmd_stb = ws_q[0] && (wd_q[3:0] != 4'h0);
        cmd_val = wd_q[3:0];
        ctrl_d[3:0] = 4'h0; // command field is a trigger, reads back zero
      end
      else if (wa_q == `TSS_SETTLE_OFS)
        settle_d = merge(settle_q, wd_q, ws_q);
      else if (wa_q == `TSS_STS_OFS)
        sts_d = sts_q & ~(merge(32'h0, wd_q, ws_q) & 32'h0000_0003);
      else if (wa_q == `TSS_MASK_OFS)
        mask_d = merge(mask_q, wd_q, ws_q) & 32'h0000_0003;
      else if (wa_q >= `TSS_RES_BASE && wa_q <= `TSS_RES_LAST && wa_q[1:0] == 2'b00)
        bresp_d = 2'b00; // results are read-only, writes dropped
      else
        bresp_d = 2'b10;
    end
    // set wins over a same-cycle clear
    if (touch_rise)
      sts_d[`TSS_STS_TOUCH_BIT] = 1'b1;
    if (done_pulse)
      sts_d[`TSS_STS_DONE_BIT] = 1'b1;
    irq_d = |(sts_d[1:0] & mask_d[1:0]);
    if (rvalid_q && rready)
    begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (arvalid && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      rdata_d = 32'h0;
      if (ra == `TSS_CTRL_OFS)
        rdata_d = ctrl_q;
      else if (ra == `TSS_SETTLE_OFS)
        rdata_d = settle_q;
      else if (ra == `TSS_STS_OFS)
      begin
        rdata_d = sts_q;
        rdata_d[`TSS_STS_BUSY_BIT] = (state_q != ST_IDLE);
        rdata_d[`TSS_STS_PEN_BIT] = touch_s;
      end
      else if (ra == `TSS_MASK_OFS)
        rdata_d = mask_q;
      else if (ra >= `TSS_RES_BASE && ra <= `TSS_RES_LAST && ra[1:0] == 2'b00)
        hit = 1'b1;
      else
        rresp_d = 2'b10;
      if (hit)
      begin
        rdata_d = {16'h0000, res_q[3'(ra[7:2] - 6'h04)]};
        rd_res_stb = 1'b1;
      end
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
    arready_d = !rvalid_d; // next read waits until the answer is taken
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= 32'h0;
      ctrl_q <= `TSS_CTRL_RST;
      settle_q <= `TSS_SETTLE_RST;
      mask_q <= `TSS_MASK_RST;
      sts_q <= 32'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      settle_q <= settle_d;
      mask_q <= mask_d;
      sts_q <= sts_d;
      irq_q <= irq_d;
    end
  end

  // scan sequencer
  always_comb
  begin
    logic start;
    logic [16:0] lead;
    logic [1:0] alog;
    logic [3:0] navg_m1;
    tss_ch_e sc;
    start = 1'b0;
    lead = LEAD_ONE;
    sc = CH_Y;
    alog = ctrl_q[`TSS_CTRL_AVG_LSB +: 2];
    navg_m1 = 4'((4'h1 << alog) - 4'h1);
    state_d = state_q;
    ch_d = ch_q;
    cnt_d = cnt_q;
    avg_d = avg_q;
    acc_d = acc_q;
    edg_d = edg_q;
    scan_d = scan_q;
    zw_d = zw_q;
    td_d = td_q;
    hdrv_d = hdrv_q;
    res_d = res_q;
    done_pulse = 1'b0;
    rdy_n_d = rdy_n_q;
    if (rd_res_stb)
      rdy_n_d = 1'b1;
    case (state_q)
      ST_IDLE:
      begin
        scan_d = 1'b0;
        zw_d = 1'b0;
        td_d = 1'b0;
        if (cmd_stb) // commands only land while idle
        begin
          case (cmd_val)
            `TSS_CMD_SCAN_XY:
            begin
              start = 1'b1;
              scan_d = 1'b1;
              lead = LEAD_XY;
            end
            `TSS_CMD_SCAN_XYZ:
            begin
              start = 1'b1;
              scan_d = 1'b1;
              zw_d = 1'b1;
              lead = LEAD_XYZ;
            end
            `TSS_CMD_ONE_X:
            begin
              start = 1'b1;
              sc = CH_X;
            end
            `TSS_CMD_ONE_Y:
              start = 1'b1;
            `TSS_CMD_ONE_Z:
            begin
              start = 1'b1;
              sc = CH_Z1;
            end
            `TSS_CMD_DRV_X:
              hdrv_d = 3'b001;
            `TSS_CMD_DRV_Y:
              hdrv_d = 3'b010;
            `TSS_CMD_DRV_Z:
              hdrv_d = 3'b100;
            `TSS_CMD_DRV_OFF:
              hdrv_d = 3'b000;
            `TSS_CMD_CONV:
            begin
              // convert the axis the host already drives
              start = (hdrv_q != 3'b000);
              sc = hdrv_q[0] ? CH_X : (hdrv_q[1] ? CH_Y : CH_Z1);
            end
            `TSS_CMD_TEMP_SINGLE_RESULT:
            begin
              start = 1'b1;
              sc = CH_T1;
            end
            `TSS_CMD_TEMP_DIFF_RESULT:
            begin
              start = 1'b1;
              sc = CH_T1;
              td_d = 1'b1;
            end
            default:
              start = 1'b0;
          endcase
        end
        else if (ctrl_q[`TSS_CTRL_AUTO_BIT] && touch_rise)
        begin
          start = 1'b1;
          scan_d = 1'b1;
          zw_d = ctrl_q[`TSS_CTRL_Z_BIT];
          lead = ctrl_q[`TSS_CTRL_Z_BIT] ? LEAD_XYZ : LEAD_XY;
        end
        if (start)
        begin
          state_d = ST_LEAD;
          ch_d = sc;
          cnt_d = lead;
          acc_d = 15'h0000;
          avg_d = 4'h0;
          edg_d = 4'h0;
          rdy_n_d = 1'b1;
        end
      end
      ST_LEAD:
      begin
        cnt_d = cnt_q - 17'h00001;
        if (cnt_q == 17'h00000)
        begin
          state_d = settles(ch_q) ? ST_SETTLE : ST_OH;
          cnt_d = settles(ch_q) ? ({1'b0, settle_q[15:0]} + {1'b0, settle_q[31:16]}) : OH_CYC;
        end
      end
      ST_SETTLE, ST_OH:
      begin
        cnt_d = cnt_q - 17'h00001;
        if (cnt_q == 17'h00000)
        begin
          state_d = (state_q == ST_SETTLE) ? ST_OH : ST_CONV;
          cnt_d = OH_CYC;
          edg_d = 4'h0;
        end
      end
      ST_CONV:
      begin
        // conversion spans one sampled converter clock edge per bit
        if (conv_rise)
        begin
          edg_d = edg_q + 4'h1;
          if (edg_q == LAST_EDGE)
          begin
            edg_d = 4'h0;
            acc_d = acc_q + {3'b000, adc_s};
            if (avg_q == navg_m1)
              state_d = ST_STORE;
            else
            begin
              avg_d = avg_q + 4'h1;
              state_d = ST_OH;
              cnt_d = OH_CYC;
            end
          end
        end
      end
      ST_STORE:
      begin
        res_d[ch_q] = {4'h0, 12'(acc_q >> alog)};
        acc_d = 15'h0000;
        avg_d = 4'h0;
        state_d = ST_IDLE;
        if (ch_q == CH_Y && scan_q && touch_s)
          ch_d = CH_X;
        else if (ch_q == CH_X && scan_q && zw_q)
          ch_d = CH_Z1;
        else if (ch_q == CH_Z1)
          ch_d = CH_Z2;
        else if (ch_q == CH_T1 && td_q)
          ch_d = CH_T2;
        else
        begin
          done_pulse = 1'b1;
          rdy_n_d = 1'b0;
        end
        if (!done_pulse)
        begin
          state_d = settles(ch_d) ? ST_SETTLE : ST_OH;
          cnt_d = settles(ch_d) ? ({1'b0, settle_q[15:0]} + {1'b0, settle_q[31:16]}) : OH_CYC;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    // axis drive follows the running channel, otherwise the host's choice
    drv_d = hdrv_d;
    if (state_d != ST_IDLE)
      drv_d = (ch_d == CH_X) ? 3'b001 : (ch_d == CH_Y) ? 3'b010 :
              (ch_d == CH_Z1 || ch_d == CH_Z2) ? 3'b100 : 3'b000;
    blo_d = (state_d != ST_IDLE) && (ch_d == CH_T1);
    bhi_d = (state_d != ST_IDLE) && (ch_d == CH_T2);
    smp_d = (state_d == ST_CONV);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      ch_q <= CH_Y;
      cnt_q <= 17'h00000;
      avg_q <= 4'h0;
      acc_q <= 15'h0000;
      edg_q <= 4'h0;
      scan_q <= 1'b0;
      zw_q <= 1'b0;
      td_q <= 1'b0;
      hdrv_q <= 3'b000;
      for (int i = 0; i < 6; i++)
        res_q[i] <= 16'h0000;
      rdy_n_q <= 1'b1;
      pen_n_q <= 1'b1;
      drv_q <= 3'b000;
      blo_q <= 1'b0;
      bhi_q <= 1'b0;
      smp_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ch_q <= ch_d;
      cnt_q <= cnt_d;
      avg_q <= avg_d;
      acc_q <= acc_d;
      edg_q <= edg_d;
      scan_q <= scan_d;
      zw_q <= zw_d;
      td_q <= td_d;
      hdrv_q <= hdrv_d;
      res_q <= res_d;
      rdy_n_q <= rdy_n_d;
      pen_n_q <= ~touch_s;
      drv_q <= drv_d;
      blo_q <= blo_d;
      bhi_q <= bhi_d;
      smp_q <= smp_d;
    end
  end

  // outputs straight from flip-flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign irq = irq_q;
  assign pen_touch_irq_n = pen_n_q;
  assign result_ready_n = rdy_n_q;
  assign drv_x = drv_q[0];
  assign drv_y = drv_q[1];
  assign drv_z = drv_q[2];
  assign temp_bias_lo = blo_q;
  assign temp_bias_hi = bhi_q;
  assign adc_sample = smp_q;
endmodule : tss_scan_top

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the touch scan sequencer
// Assumes: settle and sense counts programmed to zero for speed
// Notes: expected results and times are worked out from the level set
`timescale 1ns/10ps
`include "tss_scan_map.svh"
module tb_top;
  localparam int CONV_CYC = 8; // 160 ns converter clock in core cycles
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pen_touch = 1'b0;
  logic [11:0] level = 12'h000;
  logic alternate = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_clk, drv_x, drv_y, drv_z, irq;
  logic temp_bias_lo, temp_bias_hi, adc_sample, pen_touch_irq_n, result_ready_n;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  logic [11:0] adc_data;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h0da1;
  int exp_res[6] = '{0, 0, 0, 0, 0, 0};
  logic [3:0] cmds[7] = '{`TSS_CMD_SCAN_XY, `TSS_CMD_SCAN_XYZ, `TSS_CMD_ONE_X,
    `TSS_CMD_ONE_Y, `TSS_CMD_ONE_Z, `TSS_CMD_TEMP_SINGLE_RESULT, `TSS_CMD_TEMP_DIFF_RESULT};
  logic [5:0] chm[7] = '{6'h03, 6'h0f, 6'h01, 6'h02, 6'h0c, 6'h10, 6'h30};
  logic [4:0] sns[7] = '{5'h03, 5'h07, 5'h01, 5'h02, 5'h04, 5'h08, 5'h18};
  int leads[7] = '{`TSS_LEAD_XY_CYC, `TSS_LEAD_XYZ_CYC, `TSS_LEAD_ONE_CYC,
    `TSS_LEAD_ONE_CYC, `TSS_LEAD_ONE_CYC, `TSS_LEAD_ONE_CYC, `TSS_LEAD_ONE_CYC};
  tss_scan_top u_tss_scan_top (.*);
  tss_panel_model u_tss_panel_model (.*);
  always #10 clk = ~clk;
  // hang guard, well above the longest run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr
  // read data may be taken a cycle late, so rvalid and rdata must stand
  task automatic rd(input logic [7:0] a);
    logic late;
    late = 1'($random(seed));
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !late;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && !rready) rready <= 1'b1;
    end
    while (!(rvalid === 1'b1 && rready));
    rready <= 1'b0;
    resp = rresp;
    got = rdata;
  endtask : rd
  // collects which drivers and bias currents were used on the way
  task automatic wait_done(output int n, output logic [4:0] seen);
    n = 0;
    seen = 5'h0;
    while (result_ready_n !== 1'b0)
    begin
      @(posedge clk);
      n++;
      seen |= {temp_bias_hi, temp_bias_lo, drv_z, drv_y, drv_x};
    end
  endtask : wait_done
  task automatic chk_res;
    for (int i = 0; i < 6; i++)
    begin
      rd(`TSS_RES_BASE + 8'(4 * i));
      chk("result", 32'(exp_res[i]), got);
    end
    chk("ready_n", 32'h1, 32'(result_ready_n));
  endtask : chk_res
  initial
  begin
    int n, v, av, t, tol;
    logic [4:0] seen;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(`TSS_SETTLE_OFS);
    chk("settle reset", `TSS_SETTLE_RST, got);
    rd(8'h40);
    chk("unmapped", 32'h2, {got[29:0], resp});
    wr(8'h40, 32'h1);
    chk("unmapped wr", 32'h2, 32'(resp));
    wr(`TSS_SETTLE_OFS, 32'h0);
    // host-started mode: touch alone starts nothing, masked event stays quiet
    pen_touch <= 1'b1;
    repeat (200) @(posedge clk);
    chk("pen irq", 32'h0, 32'(pen_touch_irq_n));
    chk("idle", 32'h2, 32'({drv_x, drv_y, drv_z, adc_sample, result_ready_n, irq}));
    wr(`TSS_MASK_OFS, 32'h3);
    repeat (3) @(posedge clk);
    chk("irq on", 32'h1, 32'(irq));
    wr(`TSS_STS_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq clear", 32'h0, 32'(irq));
    // each self-timed conversion command, random level, random averaging of 1, 2 or 4 samples on all but temperature
    for (int i = 0; i < 7; i++)
    begin
      v = $unsigned($random(seed)) % 4000;
      av = (i >= 5) ? 0 : $unsigned($random(seed)) % 3;
      level <= 12'(v);
      alternate <= (av != 0);
      wr(`TSS_CTRL_OFS, {24'h0, 2'(av), 2'b00, cmds[i]});
      wait_done(n, seen);
      t = leads[i] + $countones(chm[i]) * (1 << av) * (`TSS_CONV_OH_CYC + `TSS_ADC_BITS * CONV_CYC);
      tol = $countones(chm[i]) * (1 << av) * CONV_CYC + 20;
      chk("scan time", 32'h1, 32'(n > t - tol && n < t + tol));
      chk("drive", 32'(sns[i]), 32'(seen));
      for (int j = 0; j < 6; j++)
        if (chm[i][j]) exp_res[j] = v + (av != 0);
      chk_res();
    end
    // a command while a scan runs is dropped
    v = $unsigned($random(seed)) % 4000;
    level <= 12'(v);
    alternate <= 1'b1;
    wr(`TSS_CTRL_OFS, {24'h0, 2'b01, 2'b00, `TSS_CMD_SCAN_XY});
    rd(`TSS_STS_OFS);
    chk("busy", 32'h1, 32'(got[`TSS_STS_BUSY_BIT]));
    wr(`TSS_CTRL_OFS, {24'h0, 2'b01, 2'b00, `TSS_CMD_ONE_Z});
    wait_done(n, seen);
    chk("dropped", 32'h3, 32'(seen));
    repeat (1500) @(posedge clk);
    exp_res[0] = v + 1;
    exp_res[1] = v + 1;
    chk_res();
    // host-stepped: drivers on, host delay, then convert
    wr(`TSS_CTRL_OFS, {24'h0, 2'b01, 2'b00, `TSS_CMD_DRV_X});
    // fresh level, so a missing conversion cannot pass on an old result
    v = $unsigned($random(seed)) % 4000;
    level <= 12'(v);
    repeat (20) @(posedge clk);
    chk("driver on", 32'h4, 32'({drv_x, drv_y, drv_z}));
    wr(`TSS_CTRL_OFS, {24'h0, 2'b01, 2'b00, `TSS_CMD_CONV});
    wait_done(n, seen);
    exp_res[0] = v + 1;
    chk_res();
    wr(`TSS_CTRL_OFS, {28'h0, `TSS_CMD_DRV_OFF});
    chk("driver off", 32'h0, 32'({drv_x, drv_y, drv_z}));
    // self-run on touch, with and without pressure
    for (int k = 0; k < 2; k++)
    begin
      pen_touch <= 1'b0;
      v = $unsigned($random(seed)) % 4000;
      level <= 12'(v);
      wr(`TSS_CTRL_OFS, k ? 32'h0000_0050 : 32'h0000_0070);
      repeat (10) @(posedge clk);
      pen_touch <= 1'b1;
      wait_done(n, seen);
      chk("self drive", k ? 32'h3 : 32'h7, 32'(seen));
      for (int j = 0; j < (k ? 2 : 4); j++)
        exp_res[j] = v + 1;
      chk_res();
    end
    test_done();
  end
endmodule : tb_top
bind tss_scan_top tss_scan_checker u_tss_scan_checker (.*);

// >>> dv/tss_panel_model.sv
// Purpose: panel and converter stand-in for the scan sequencer
// Assumes: the bench sets the converter level before each run
// Notes: converter clock runs only while the sequencer samples
`timescale 1ns/10ps
module tss_panel_model
(
  // sequencer side
  input wire logic adc_sample,
  input wire logic [11:0] level,
  input wire logic alternate,
  // converter side
  output logic conv_clk,
  output logic [11:0] adc_data
);
  logic odd_q = 1'b0;
  // samples alternate by two, so any even average lands one above the level
  always @(posedge adc_sample)
    odd_q <= ~odd_q;
  // clock halts between frames, edges land 3 ns before a core clock rising edge
  initial
  begin
    conv_clk = 1'b0;
    #7;
    forever
    begin
      #80;
      conv_clk = adc_sample ? ~conv_clk : 1'b0;
    end
  end
  // a released bus shows the inverse, never a stale value
  assign adc_data = !adc_sample ? ~level : (odd_q && alternate) ? level + 12'h002 : level;
endmodule : tss_panel_model

// >>> dv/tss_scan_checker.sv
// Purpose: port-level checks of the touch scan sequencer
// Assumes: bench drives inputs just after the sampling edge
// Notes: sample span figure follows a 160 ns converter clock
`timescale 1ns/10ps
module tss_scan_checker
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // panel and signalling
  input wire logic pen_touch,
  input wire logic drv_x,
  input wire logic drv_y,
  input wire logic drv_z,
  input wire logic temp_bias_lo,
  input wire logic temp_bias_hi,
  input wire logic adc_sample,
  input wire logic pen_touch_irq_n,
  input wire logic result_ready_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // touch shows on the pin after two sync flops and the output register
  pen_irq_a: assert property ($past(srst, 3) == 1'b0 |-> pen_touch_irq_n == !$past(pen_touch, 3))
    else $error("pen interrupt does not follow touch");
  // only one axis may be driven, two at once would short the panel
  one_axis_a: assert property ($onehot0({drv_x, drv_y, drv_z}))
    else $error("more than one axis driven");
  sample_cause_a: assert property (adc_sample |-> drv_x | drv_y | drv_z | temp_bias_lo | temp_bias_hi)
    else $error("conversion with nothing driven");
  temp_axis_a: assert property (temp_bias_lo | temp_bias_hi |-> !(drv_x | drv_y | drv_z))
    else $error("axis driven during temperature");
  bias_excl_a: assert property (!(temp_bias_lo && temp_bias_hi))
    else $error("both bias currents on");
  // twelve converter clocks take far more than eight core cycles
  sample_span_a: assert property ($rose(adc_sample) |=> adc_sample [*8])
    else $error("conversion cut short");
  ready_fall_a: assert property ($fell(result_ready_n) |-> !adc_sample)
    else $error("results flagged during a conversion");
  rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("control write not answered");
  read_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read not answered");
  // main scenarios
  cover property ($fell(result_ready_n));
  cover property (temp_bias_hi && adc_sample);
  cover property (drv_z && adc_sample);
endmodule : tss_scan_checker
